// ---- src/clock_reset_option_config.sv ----
// Clock, start-up delay and low-voltage detector configuration with an
// AXI4-Lite register port. Option bytes arrive from option memory on aclk
// and are held from reset; the reset pin and supply-valid are asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - The six-bit CPU divider code gives no division at zero, 2^(n+1) for one set bit n, else 64.
// - Source code 00 picks the internal oscillator, 01 the external clock or crystal, 1x the RC oscillator.
// - Gain code 000/001/011/101/111 enables 0/1/3/6/8 stages; 010, 100 and 110 are illegal.
// - The six-bit trim value switches current generators, about 100 kHz per step.
// - External, power-on and halt wake-up hold the CPU 4096 times (prescaler plus one) cycles.
// - With the internal oscillator the wake-up prescaler is ignored and no prescaled count runs.
// - The oscillator feeds a divided CPU clock and an undivided peripheral clock.
// - Detector or watchdog resets restart the CPU at once with no delay.
// - After supply is valid a fixed 4096-cycle count runs before any prescaled count.
module clock_reset_option_config #(
  parameter int STAB_UNIT = 4096
) (
  // Clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // AXI4-Lite write
  input  wire logic [clkcfg_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [clkcfg_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  // AXI4-Lite read
  input  wire logic [clkcfg_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [clkcfg_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  // Option memory
  input  wire logic                            opt_valid,
  input  wire logic [7:0]                      opt_source_byte,
  input  wire logic [7:0]                      opt_gain_byte,
  input  wire logic [7:0]                      opt_trim_byte,
  input  wire logic [7:0]                      opt_threshold_byte,
  input  wire logic [7:0]                      opt_startup_byte,
  // Reset and wake sources
  input  wire logic                            ext_reset_n,
  input  wire logic                            supply_valid,
  input  wire logic                            por_event,
  input  wire logic                            halt_wake,
  input  wire logic                            lvd_reset,
  input  wire logic                            wdog_reset,
  // Oscillator and detector controls
  output clkcfg_pkg::osc_sel_t                 osc_select,
  output logic [7:0]                           gain_stage_en,
  output logic [5:0]                           trim_enable,
  output logic                                 lvd_enable,
  output logic [1:0]                           lvd_level,
  // Clocks out
  output logic                                 cpu_run,
  output logic                                 cpu_tick,
  output logic                                 periph_tick
);

  // Option bytes, held static from reset.
  logic [1:0] source_r, source_nxt;
  logic [2:0] gain_r, gain_nxt;
  logic [5:0] trim_r, trim_nxt;
  logic [1:0] thresh_r, thresh_nxt;
  logic [7:0] startup_r, startup_nxt;

  always_comb begin
    source_nxt  = opt_valid ? opt_source_byte[1:0]    : clkcfg_pkg::RST_SOURCE[1:0];
    gain_nxt    = opt_valid ? opt_gain_byte[2:0]      : clkcfg_pkg::RST_GAIN[2:0];
    trim_nxt    = opt_valid ? opt_trim_byte[5:0]      : clkcfg_pkg::RST_TRIM[5:0];
    thresh_nxt  = opt_valid ? opt_threshold_byte[1:0] : clkcfg_pkg::RST_THRESH[1:0];
    startup_nxt = opt_valid ? opt_startup_byte        : clkcfg_pkg::RST_STARTUP;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_r  <= source_nxt;
      gain_r    <= gain_nxt;
      trim_r    <= trim_nxt;
      thresh_r  <= thresh_nxt;
      startup_r <= startup_nxt;
    end
  end

  // Two-flop synchronisers for the reset pin and supply-valid.
  logic [1:0] sync1_r, sync2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= clkcfg_pkg::SYNC_RST;
      sync2_r <= clkcfg_pkg::SYNC_RST;
    end else begin
      sync1_r <= {supply_valid, ext_reset_n};
      sync2_r <= sync1_r;
    end
  end

  logic cold_event, warm_event, supply_ok, src_internal;
  logic [clkcfg_pkg::CNT_W-1:0] prescale_limit, fixed_last;
  assign cold_event     = !sync2_r[0] || por_event || halt_wake;
  assign warm_event     = lvd_reset || wdog_reset;
  assign supply_ok      = sync2_r[1];
  assign src_internal   = (source_r == clkcfg_pkg::SRC_INTERNAL);
  assign fixed_last     = clkcfg_pkg::CNT_W'(clkcfg_pkg::FIXED_CYCLES - 1);
  assign prescale_limit = clkcfg_pkg::CNT_W'((int'(startup_r) + 1) * STAB_UNIT - 1);

  // Start-up sequencer.
  clkcfg_pkg::start_state_t     state_r, state_nxt;
  logic [clkcfg_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + clkcfg_pkg::CNT_W'(1);
    if (cold_event) begin
      state_nxt = clkcfg_pkg::ST_SUPPLY;
      cnt_nxt   = '0;
    end else if (warm_event) begin
      state_nxt = clkcfg_pkg::ST_RUN;
      cnt_nxt   = '0;
    end else begin
      unique case (state_r)
        clkcfg_pkg::ST_SUPPLY: begin
          cnt_nxt = '0;
          if (supply_ok) state_nxt = clkcfg_pkg::ST_FIXED;
        end
        clkcfg_pkg::ST_FIXED: begin
          if (cnt_r == fixed_last) begin
            cnt_nxt = '0;
            state_nxt = src_internal ? clkcfg_pkg::ST_RUN : clkcfg_pkg::ST_PRESCALE;
          end
        end
        clkcfg_pkg::ST_PRESCALE: begin
          if (cnt_r == prescale_limit) begin
            cnt_nxt   = '0;
            state_nxt = clkcfg_pkg::ST_RUN;
          end
        end
        clkcfg_pkg::ST_RUN: cnt_nxt = '0;
        default: begin
          state_nxt = clkcfg_pkg::ST_SUPPLY;
          cnt_nxt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= clkcfg_pkg::ST_SUPPLY;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Registered oscillator and detector controls.
  clkcfg_pkg::osc_sel_t osc_r, osc_nxt;
  logic [7:0] gain_en_r, gain_en_nxt;
  logic [5:0] trim_en_r, trim_en_nxt;
  logic       lvd_en_r, lvd_en_nxt, periph_r;
  logic [1:0] lvd_lvl_r, lvd_lvl_nxt;
  logic [3:0] stages;

  always_comb begin
    if (source_r[1]) begin
      osc_nxt = clkcfg_pkg::OSC_RC;
    end else if (src_internal) begin
      osc_nxt = clkcfg_pkg::OSC_INTERNAL;
    end else begin
      osc_nxt = clkcfg_pkg::OSC_EXTERNAL;
    end
    stages = clkcfg_pkg::gain_stages(gain_r);
    // trim generators; out-of-range values are held at the ceiling.
    trim_en_nxt = (trim_r > clkcfg_pkg::TRIM_MAX) ? clkcfg_pkg::TRIM_MAX : trim_r;
    lvd_en_nxt  = (thresh_r != clkcfg_pkg::THR_OFF);
    lvd_lvl_nxt = thresh_r;
  end

  for (genvar g = 0; g < 8; g++) begin : g_stage
    assign gain_en_nxt[g] = (4'(g) < stages);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_r     <= clkcfg_pkg::OSC_INTERNAL;
      gain_en_r <= 8'h00;
      trim_en_r <= 6'h00;
      lvd_en_r  <= 1'b0;
      lvd_lvl_r <= 2'h0;
      periph_r  <= 1'b0;
    end else begin
      osc_r     <= osc_nxt;
      gain_en_r <= gain_en_nxt;
      trim_en_r <= trim_en_nxt;
      lvd_en_r  <= lvd_en_nxt;
      lvd_lvl_r <= lvd_lvl_nxt;
      periph_r  <= 1'b1;
    end
  end

  assign osc_select    = osc_r;
  assign gain_stage_en = gain_en_r;
  assign trim_enable   = trim_en_r;
  assign lvd_enable    = lvd_en_r;
  assign lvd_level     = lvd_lvl_r;
  assign periph_tick   = periph_r;
  assign cpu_run       = (state_r == clkcfg_pkg::ST_RUN);

  // AXI4-Lite slave.
  logic       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [5:0] aw_idx_r, aw_idx_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic       wlane_r, wlane_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [clkcfg_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [5:0] cpudiv_r, cpudiv_nxt, rd_idx;
  logic       wr_fire;

  assign awready = !aw_have_r && !bvalid_r;
  assign wready  = !w_have_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign rd_idx  = araddr[7:2];

  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_idx_nxt  = aw_idx_r;
    w_have_nxt  = w_have_r;
    wbyte_nxt   = wbyte_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = bvalid_r && !bready;
    bresp_nxt   = bresp_r;
    cpudiv_nxt  = cpudiv_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      aw_idx_nxt  = awaddr[7:2];
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      wbyte_nxt  = wdata[7:0];
      wlane_nxt  = wstrb[0];
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = clkcfg_pkg::RESP_SLVERR;
      if (aw_idx_r == clkcfg_pkg::IDX_CPUDIV) begin
        bresp_nxt = clkcfg_pkg::RESP_OKAY;
        if (wlane_r) cpudiv_nxt = wbyte_r[5:0];
      end
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r && !rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = clkcfg_pkg::RESP_OKAY;
      rdata_nxt  = '0;
      case (rd_idx)
        clkcfg_pkg::IDX_SOURCE:  rdata_nxt[1:0] = source_r;
        clkcfg_pkg::IDX_GAIN:    rdata_nxt[2:0] = gain_r;
        clkcfg_pkg::IDX_TRIM:    rdata_nxt[5:0] = trim_r;
        clkcfg_pkg::IDX_THRESH:  rdata_nxt[1:0] = thresh_r;
        clkcfg_pkg::IDX_STARTUP: rdata_nxt[7:0] = startup_r;
        clkcfg_pkg::IDX_CPUDIV:  rdata_nxt[5:0] = cpudiv_r;
        clkcfg_pkg::IDX_STATUS: begin
          rdata_nxt[clkcfg_pkg::STAT_RUN]      = cpu_run;
          rdata_nxt[clkcfg_pkg::STAT_STAB]     = !cpu_run && (state_r != clkcfg_pkg::ST_SUPPLY);
          rdata_nxt[clkcfg_pkg::STAT_GAIN_BAD] = !clkcfg_pkg::gain_legal(gain_r);
        end
        default: rresp_nxt = clkcfg_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_idx_r  <= 6'h00;
      w_have_r  <= 1'b0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= clkcfg_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= clkcfg_pkg::RESP_OKAY;
      cpudiv_r  <= clkcfg_pkg::RST_CPUDIV;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_have_r  <= w_have_nxt;
      wbyte_r   <= wbyte_nxt;
      wlane_r   <= wlane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      cpudiv_r  <= cpudiv_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;

  cpu_clock_div u_cpu_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .div_code (cpudiv_r),
    .run      (cpu_run),
    .cpu_tick (cpu_tick)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_warm_restart: assert property (warm_event && !cold_event |=> cpu_run)
    else $error("warm reset did not restart at once");
  a_supply_fixed: assert property (state_r == clkcfg_pkg::ST_SUPPLY && supply_ok && !cold_event && !warm_event
      |=> state_r == clkcfg_pkg::ST_FIXED && cnt_r == '0)
    else $error("fixed count did not follow supply");
  a_internal_skip: assert property (state_r == clkcfg_pkg::ST_FIXED && cnt_r == fixed_last && src_internal
      && !cold_event && !warm_event |=> cpu_run)
    else $error("internal source ran a prescaled count");
  a_external_wait: assert property (state_r == clkcfg_pkg::ST_FIXED && cnt_r == fixed_last && !src_internal
      && !cold_event && !warm_event |=> state_r == clkcfg_pkg::ST_PRESCALE)
    else $error("external source skipped the prescaled count");
  a_prescale_end: assert property (state_r == clkcfg_pkg::ST_PRESCALE && cnt_r == prescale_limit
      && !cold_event && !warm_event |=> cpu_run)
    else $error("prescaled count did not end at its limit");
  a_source_rc: assert property ($past(aresetn) && source_r[1] |-> osc_select == clkcfg_pkg::OSC_RC)
    else $error("rc source not selected");
  a_gain_illegal: assert property ($past(aresetn) && !clkcfg_pkg::gain_legal(gain_r) |-> gain_stage_en == 8'h00)
    else $error("illegal gain code enabled stages");
  a_options_static: assert property ($past(aresetn) |-> $stable(source_r) && $stable(startup_r))
    else $error("option byte changed outside reset");
  a_lvd_off: assert property ($past(aresetn) && thresh_r == clkcfg_pkg::THR_OFF |-> !lvd_enable)
    else $error("detector enabled while off");
  a_trim_ceiling: assert property ($past(aresetn) |-> trim_enable <= clkcfg_pkg::TRIM_MAX)
    else $error("trim above ceiling");
  a_periph_free: assert property ($past(aresetn) |-> periph_tick)
    else $error("peripheral clock stopped");

  c_prescale_run: cover property (state_r == clkcfg_pkg::ST_PRESCALE ##1 cpu_run);
  c_warm_restart: cover property (warm_event && state_r == clkcfg_pkg::ST_FIXED);
  c_div_write:    cover property (wr_fire && aw_idx_r == clkcfg_pkg::IDX_CPUDIV);

endmodule : clock_reset_option_config

// ---- pkg/clkcfg_pkg.sv ----
// Constants, encodings and decode helpers shared by the clock, start-up and
// option configuration block and its CPU clock divider.
// Assumes a single oscillator-derived clock and word-aligned AXI4-Lite access.
package clkcfg_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          CNT_W        = 21;
  localparam int          FIXED_CYCLES = 4096;

  // Register indexes; byte address is four times the index.
  localparam logic [5:0]  IDX_SOURCE   = 6'h00;
  localparam logic [5:0]  IDX_GAIN     = 6'h01;
  localparam logic [5:0]  IDX_TRIM     = 6'h02;
  localparam logic [5:0]  IDX_THRESH   = 6'h03;
  localparam logic [5:0]  IDX_STARTUP  = 6'h07;
  localparam logic [5:0]  IDX_CPUDIV   = 6'h2E;
  localparam logic [5:0]  IDX_STATUS   = 6'h30;

  localparam logic [7:0]  RST_SOURCE   = 8'h00;
  localparam logic [7:0]  RST_GAIN     = 8'h00;
  localparam logic [7:0]  RST_TRIM     = 8'h14;
  localparam logic [7:0]  RST_THRESH   = 8'h02;
  localparam logic [7:0]  RST_STARTUP  = 8'h00;
  localparam logic [5:0]  RST_CPUDIV   = 6'h00;
  localparam logic [5:0]  TRIM_MAX     = 6'h28;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  localparam logic [1:0]  SRC_INTERNAL = 2'h0;
  localparam logic [1:0]  THR_OFF      = 2'h0;
  localparam logic [1:0]  THR_MED      = 2'h1;
  localparam logic [1:0]  THR_LOW      = 2'h2;

  // Status bit positions.
  localparam int          STAT_RUN     = 0;
  localparam int          STAT_STAB    = 1;
  localparam int          STAT_GAIN_BAD = 2;

  // Synchroniser reset: reset pin idles high, supply-valid idles low.
  localparam logic [1:0]  SYNC_RST     = 2'h1;

  typedef enum logic [2:0] {
    OSC_INTERNAL = 3'h1,
    OSC_EXTERNAL = 3'h2,
    OSC_RC       = 3'h4
  } osc_sel_t;

  typedef enum logic [3:0] {
    ST_SUPPLY   = 4'h1,
    ST_FIXED    = 4'h2,
    ST_PRESCALE = 4'h4,
    ST_RUN      = 4'h8
  } start_state_t;

  // Divide ratio as a power of two: zero is undivided, one set bit at n is
  // a shift of n+1, anything else saturates at a shift of six.
  function automatic logic [2:0] div_shift(input logic [5:0] code);
    logic [5:0] below;
    below = code - 6'h01;
    if (code == 6'h00) begin
      div_shift = 3'h0;
    end else if ((code & below) == 6'h00) begin
      div_shift = 3'h6;
      for (int i = 0; i < 6; i++) begin
        if (code[i]) div_shift = 3'(i + 1);
      end
    end else begin
      div_shift = 3'h6;
    end
  endfunction : div_shift

  function automatic logic gain_legal(input logic [2:0] code);
    gain_legal = (code == 3'h0) || code[0];
  endfunction : gain_legal

  function automatic logic [3:0] gain_stages(input logic [2:0] code);
    case (code)
      3'h1:    gain_stages = 4'h1;
      3'h3:    gain_stages = 4'h3;
      3'h5:    gain_stages = 4'h6;
      3'h7:    gain_stages = 4'h8;
      default: gain_stages = 4'h0;
    endcase
  endfunction : gain_stages

endpackage : clkcfg_pkg

// ---- src/cpu_clock_div.sv ----
// CPU clock divider: one-cycle CPU tick every 2^shift oscillator cycles.
// Assumes the divider code comes from a register on the same clock.
`timescale 1ns/1ps
module cpu_clock_div (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic [5:0] div_code,
  input  wire logic       run,
  // Output
  output logic            cpu_tick
);

  logic [2:0] shift_r, shift_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic       tick_r, tick_nxt;
  logic [6:0] span;
  logic       boundary;

  always_comb begin
    span      = (7'h01 << shift_r) - 7'h01;
    boundary  = (cnt_r == span[5:0]);
    cnt_nxt   = boundary ? 6'h00 : cnt_r + 6'h01;
    shift_nxt = boundary ? clkcfg_pkg::div_shift(div_code) : shift_r;
    tick_nxt  = run && boundary;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= 3'h0;
      cnt_r   <= 6'h00;
      tick_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign cpu_tick = tick_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_div_undivided: assert property (run && shift_r == 3'h0 |=> cpu_tick)
    else $error("undivided ratio missed a tick");
  a_div_slowest: assert property (run && shift_r == 3'h6 && cpu_tick |=> !cpu_tick[*8])
    else $error("ratio 64 ticked too soon");

endmodule : cpu_clock_div

// ---- verification/osc_option_model.sv ----
// Option memory and supply monitor that face the clock block.
// Assumes the bench selects a configuration while reset is held.
`timescale 1ns/1ps
module osc_option_model (
  // Clock and cold sources
  input  wire logic       aclk,
  input  wire logic       ext_reset_n,
  input  wire logic       por_event,
  input  wire logic [2:0] cfg,
  // Option bytes and supply
  output logic            opt_valid,
  output logic [7:0]      opt_source_byte,
  output logic [7:0]      opt_gain_byte,
  output logic [7:0]      opt_trim_byte,
  output logic [7:0]      opt_threshold_byte,
  output logic [7:0]      opt_startup_byte,
  output logic            supply_valid
);
  localparam logic [7:0] SRC [7]  = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h01, 8'h02, 8'h01};
  localparam logic [7:0] GAIN [7] = '{8'h03, 8'h00, 8'h01, 8'h05, 8'h07, 8'h05, 8'h00};
  localparam logic [7:0] TRIM [7] = '{8'h28, 8'h14, 8'h14, 8'h14, 8'h00, 8'h20, 8'h14};
  localparam logic [7:0] THR [7]  = '{8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h03, 8'h02};
  localparam logic [7:0] WAKE [7] = '{8'h03, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00};
  logic [2:0]            up_r     = 3'h0;
  // Entry five marks the option memory blank; its bytes differ from the
  // defaults so that a block which ignores the valid flag is caught.
  assign opt_valid          = cfg != 3'h5;
  assign opt_source_byte    = SRC[cfg];
  assign opt_gain_byte      = GAIN[cfg];
  assign opt_trim_byte      = TRIM[cfg];
  assign opt_threshold_byte = THR[cfg];
  assign opt_startup_byte   = WAKE[cfg];
  // Supply comes good a few cycles after a cold source lets go.
  always_ff @(posedge aclk) begin
    if (!ext_reset_n || por_event) up_r <= 3'h0;
    else if (up_r != 3'h4) up_r <= up_r + 3'h1;
  end
  assign supply_valid = up_r == 3'h4;
endmodule : osc_option_model

// ---- verification/tb.sv ----
// Self-checking bench for the clock, start-up and option block.
// Assumes the option memory model and a prescaled unit of 8 cycles.
`timescale 1ns/1ps
module tb;
  localparam logic [1:0] OK = clkcfg_pkg::RESP_OKAY;
  localparam logic [1:0] SE = clkcfg_pkg::RESP_SLVERR;
  localparam logic [2:0] OSC [7] = '{3'h2, 3'h1, 3'h4, 3'h4, 3'h2, 3'h1, 3'h2};
  localparam logic [7:0] SRC [7] = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h01, 8'h00, 8'h01};
  localparam logic [7:0] GC [7]  = '{8'h03, 8'h00, 8'h01, 8'h05, 8'h07, 8'h00, 8'h00};
  localparam int         NST [7] = '{3, 0, 1, 6, 8, 0, 0};
  localparam logic [7:0] TRM [7] = '{8'h28, 8'h14, 8'h14, 8'h14, 8'h00, 8'h14, 8'h14};
  localparam logic [7:0] THR [7] = '{8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h02, 8'h02};
  localparam logic [7:0] WK [7]  = '{8'h03, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [5:0] DV [9]  = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h03, 6'h3F};
  localparam int         PD [9]  = '{1, 2, 4, 8, 16, 32, 64, 64, 64};
  logic                  aclk = 1'b0, aresetn = 1'b0, ext_reset_n = 1'b0;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                  por_event = 1'b0, halt_wake = 1'b0, lvd_reset = 1'b0, wdog_reset = 1'b0;
  logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]           wdata = 32'h0;
  logic [3:0]            wstrb = 4'hF;
  logic [2:0]            cfg = 3'h0;
  logic                  awready, wready, bvalid, arready, rvalid, opt_valid, supply_valid;
  logic                  lvd_enable, cpu_run, cpu_tick, periph_tick;
  logic [1:0]            bresp, rresp, lvd_level;
  logic [31:0]           rdata;
  logic [7:0]            opt_source_byte, opt_gain_byte, opt_trim_byte, opt_threshold_byte;
  logic [7:0]            opt_startup_byte, gain_stage_en;
  logic [5:0]            trim_enable;
  clkcfg_pkg::osc_sel_t  osc_select;
  int                    err_count = 0, cmp_count = 0;

  clock_reset_option_config #(.STAB_UNIT(8)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .opt_valid, .opt_source_byte, .opt_gain_byte,
    .opt_trim_byte, .opt_threshold_byte, .opt_startup_byte, .ext_reset_n, .supply_valid, .por_event, .halt_wake,
    .lvd_reset, .wdog_reset, .osc_select, .gain_stage_en, .trim_enable, .lvd_enable, .lvd_level, .cpu_run,
    .cpu_tick, .periph_tick
  );
  osc_option_model osc (
    .aclk, .ext_reset_n, .por_event, .cfg, .opt_valid, .opt_source_byte, .opt_gain_byte, .opt_trim_byte,
    .opt_threshold_byte, .opt_startup_byte, .supply_valid
  );

  initial forever #12.5 aclk = ~aclk;

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    chk(bvalid === 1'b1, "write answer");
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    chk(rvalid === 1'b1 && rdata === ed && rresp === er, "register read");
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Options are captured during reset, so each configuration needs a fresh one.
  task automatic rst(input logic [2:0] c);
    cfg <= c;
    aresetn <= 1'b0;
    ext_reset_n <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    ext_reset_n <= 1'b1;
    @(posedge aclk);
    #1;
  endtask : rst

  task automatic wait_run(input int lo);
    int n = 0;
    while (cpu_run !== 1'b1 && n < 6000) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk(n >= lo && n <= lo + 6, "start-up length");
  endtask : wait_run

  task automatic pulse(input logic [3:0] v);
    {wdog_reset, lvd_reset, por_event, halt_wake} <= v;
    @(posedge aclk);
    {wdog_reset, lvd_reset, por_event, halt_wake} <= 4'h0;
    #1;
  endtask : pulse

  task automatic t_options;
    for (int c = 0; c < 7; c++) begin
      rst(3'(c));
      chk(osc_select === OSC[c], "source select");
      chk(gain_stage_en === 8'((9'h1 << NST[c]) - 9'h1), "gain stages");
      chk(trim_enable === TRM[c][5:0], "trim");
      chk(lvd_enable === (THR[c] != 8'h00) && lvd_level === THR[c][1:0], "detector");
      rd(8'h00, {24'h0, SRC[c]}, OK);
      rd(8'h04, {24'h0, GC[c]}, OK);
      rd(8'h08, {24'h0, TRM[c]}, OK);
      rd(8'h0C, {24'h0, THR[c]}, OK);
      rd(8'h1C, {24'h0, WK[c]}, OK);
      rd(8'hB8, 32'h0, OK);
    end
  endtask : t_options

  task automatic t_warm;
    pulse(4'h2);
    chk(cpu_run === 1'b0, "cold restart");
    repeat (40) @(posedge aclk);
    pulse(4'h4);
    @(posedge aclk);
    #1;
    chk(cpu_run === 1'b1, "detector restart");
    pulse(4'h2);
    repeat (40) @(posedge aclk);
    pulse(4'h8);
    @(posedge aclk);
    #1;
    chk(cpu_run === 1'b1, "watchdog restart");
  endtask : t_warm

  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      chk(periph_tick === 1'b1, "peripheral clock");
    end while (cpu_tick !== 1'b1 && n < 200);
  endtask : next_tick

  task automatic t_div;
    logic [1:0] r;
    int         n;
    for (int i = 0; i < 9; i++) begin
      wr(8'hB8, {24'hFFFFFF, 2'h3, DV[i]}, r);
      chk(r === OK, "divider write");
      rd(8'hBA, {26'h0, DV[i]}, OK);
      next_tick(n);
      next_tick(n);
      next_tick(n);
      chk(n == PD[i], "cpu clock ratio");
    end
  endtask : t_div

  task automatic t_regs;
    logic [1:0] r;
    wr(8'h08, 32'h3F, r);
    chk(r === SE, "read-only write");
    rd(8'h08, 32'h28, OK);
    rd(8'h40, 32'h0, SE);
    rd(8'hC0, 32'h1, OK);
  endtask : t_regs

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  initial begin
    #1000000;
    err_count++;
    results;
  end

  initial begin
    t_options;
    rst(3'h1);
    wait_run(4096 + 3);
    rst(3'h0);
    wait_run(4096 + 32 + 3);
    pulse(4'h1);
    wait_run(4096 + 32);
    t_warm;
    t_div;
    t_regs;
    results;
  end
endmodule : tb
